/* File: rtl/hplf_regs.svh */
// Constants for the host packet link framer: line timing, packet limits and checksum.
// Assumes a 40 MHz system clock; included by its bare name.
`ifndef HPLF_REGS_SVH
`define HPLF_REGS_SVH

`define HPLF_CLK_HZ 40000000
`define HPLF_BAUD_HZ 115200
`define HPLF_BAUD_DIV (`HPLF_CLK_HZ / `HPLF_BAUD_HZ)
`define HPLF_BITS_PER_CHAR 10
`define HPLF_MAX_LEN 8'h16
`define HPLF_RPT_MAX_LEN 3'h4
`define HPLF_ECHO_CODE 6'h00
`define HPLF_CRC_INIT 16'hFFFF
`define HPLF_CRC_POLY 16'h8408
`define HPLF_RESP_LIMIT_MS 250
`define HPLF_RESP_LIMIT_CYC ((`HPLF_CLK_HZ / 1000) * `HPLF_RESP_LIMIT_MS)
`define HPLF_TX_WORST_CYC (40 * `HPLF_BITS_PER_CHAR * `HPLF_BAUD_DIV)

`endif

/* File: rtl/hplf_pkg.sv */
// Types shared by the host packet link framer and its user.
// Assumes nothing beyond a SystemVerilog compiler.
package hplf_pkg;

  typedef enum logic [1:0] {
    HPLF_CLS_CMD = 2'h0,
    HPLF_CLS_RSP = 2'h1,
    HPLF_CLS_RPT = 2'h2,
    HPLF_CLS_ERR = 2'h3
  } hplf_class_t;

  typedef struct packed {
    logic [5:0] code;
    logic [4:0] len;
  } hplf_cmd_t;

  typedef struct packed {
    logic err;
    logic [4:0] len;
  } hplf_ans_t;

  typedef struct packed {
    logic [5:0] code;
    logic [2:0] len;
    logic [31:0] data;
  } hplf_rpt_t;

endpackage

/* File: rtl/hplf_fifo.sv */
// Byte FIFO between the packet builder and the serial transmitter.
// Assumes one clock and a synchronous active-high reset.
module hplf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rp_q];

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end
endmodule // hplf_fifo

/* File: rtl/hplf_framer.sv */
// Host packet link framer: serial line, packet receiver, answer logic and packet sender.
// Assumes one 40 MHz clock, synchronous inputs and a user that answers commands.
// Function
// - Packet order is type, length, payload, then two checksum bytes.
// - Type top two bits: 00 command, 01 response, 10 report, 11 error.
// - Type low six bits carry the code, 0 to 63.
// - Well-formed packet with illegal content is answered with an error-class packet.
// - Length byte counts payload bytes; only 0 to 22 valid.
// - 16-bit checksum over type, length and payload; receiver checks it.
// - Checksum sent low byte first, right after last used payload byte.
// - Line runs at 115200 baud, 8 data bits, no parity, one stop bit.
// - Every accepted packet is answered within 250 ms of its end; packets dropped for length, checksum or busy get no answer.
// - No flow-control lines or characters; acknowledgement only.
// - Reports may interleave with acknowledges; host classifies by type byte.
// - Each accepted command gets exactly one response or error with the same code.
// - Echo command (code 0) returns same length and payload with type 0x40.
`include "hplf_regs.svh"

module hplf_framer #(
  parameter int P_ANS_LIMIT_CYC = `HPLF_RESP_LIMIT_CYC - `HPLF_TX_WORST_CYC,
  parameter int P_BAUD_DIV = `HPLF_BAUD_DIV,
  parameter int P_FIFO_DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_cmd_valid,
  output hplf_pkg::hplf_cmd_t o_cmd,
  input wire logic [4:0] i_cmd_idx,
  output logic [7:0] o_cmd_byte,
  input wire logic i_ans_wr,
  input wire logic [7:0] i_ans_byte,
  input wire logic i_ans_valid,
  input wire hplf_pkg::hplf_ans_t i_ans,
  input wire logic i_rpt_valid,
  input wire hplf_pkg::hplf_rpt_t i_rpt,
  output logic o_rpt_taken,
  output logic o_drop,
  output logic o_busy
);
  typedef enum logic [2:0] {
    R_TYPE = 3'b000, R_LEN = 3'b001, R_DATA = 3'b011, R_CRCL = 3'b010, R_CRCH = 3'b110
  } hplf_rx_st_t;
  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_TYPE = 3'b001, T_LEN = 3'b011, T_DATA = 3'b010,
    T_CRCL = 3'b110, T_CRCH = 3'b111
  } hplf_tx_st_t;

  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `HPLF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Serial receiver. The divider restarts on each start edge, giving a mid-bit enable.
  logic rxd_q, ur_act_q, ur_act_d, rx_stb_q, rx_stb_d;
  logic [15:0] ur_div_q, ur_div_d;
  logic [3:0] ur_bit_q, ur_bit_d;
  logic [7:0] ur_sh_q, ur_sh_d, rx_byte_q, rx_byte_d;

  always_comb begin
    ur_act_d = ur_act_q;
    ur_div_d = ur_div_q;
    ur_bit_d = ur_bit_q;
    ur_sh_d = ur_sh_q;
    rx_byte_d = rx_byte_q;
    rx_stb_d = 1'b0;
    if (!ur_act_q) begin
      if (!rxd_q) begin
        ur_act_d = 1'b1;
        ur_div_d = 16'(P_BAUD_DIV / 2);
        ur_bit_d = '0;
      end
    end else if (ur_div_q != '0) begin
      ur_div_d = ur_div_q - 1'b1;
    end else begin
      ur_div_d = 16'(P_BAUD_DIV - 1);
      ur_bit_d = ur_bit_q + 1'b1;
      if (ur_bit_q == 4'h0) begin
        ur_act_d = !rxd_q;
      end else if (ur_bit_q != 4'h9) begin
        ur_sh_d = {rxd_q, ur_sh_q[7:1]};
      end else begin
        ur_act_d = 1'b0;
        rx_stb_d = rxd_q;
        rx_byte_d = ur_sh_q;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rxd_q <= 1'b1;
      ur_act_q <= 1'b0;
      ur_div_q <= '0;
      ur_bit_q <= '0;
      ur_sh_q <= '0;
      rx_byte_q <= '0;
      rx_stb_q <= 1'b0;
    end else begin
      rxd_q <= i_rxd;
      ur_act_q <= ur_act_d;
      ur_div_q <= ur_div_d;
      ur_bit_q <= ur_bit_d;
      ur_sh_q <= ur_sh_d;
      rx_byte_q <= rx_byte_d;
      rx_stb_q <= rx_stb_d;
    end
  end

  // Payload buffer shared by the receiver, the user's answer and the sender.
  logic [7:0] buf_q [`HPLF_MAX_LEN];
  logic buf_we;
  logic [4:0] buf_wa;
  logic [7:0] buf_wd;

  // Packet receiver.
  hplf_rx_st_t rs_q, rs_d;
  logic [7:0] rtype_q, rtype_d, rcvl_q, rcvl_d;
  logic [4:0] rlen_q, rlen_d, ridx_q, ridx_d;
  logic [15:0] rcrc_q, rcrc_d;
  logic rkeep_q, rkeep_d, good, drop_d, hold;

  always_comb begin
    rs_d = rs_q;
    rtype_d = rtype_q;
    rcvl_d = rcvl_q;
    rlen_d = rlen_q;
    ridx_d = ridx_q;
    rcrc_d = rcrc_q;
    rkeep_d = rkeep_q;
    good = 1'b0;
    drop_d = 1'b0;
    buf_we = 1'b0;
    buf_wa = i_cmd_idx;
    buf_wd = i_ans_byte;
    if (rx_stb_q) begin
      unique case (rs_q)
        R_TYPE: begin
          rtype_d = rx_byte_q;
          rcrc_d = crc_next(`HPLF_CRC_INIT, rx_byte_q);
          rkeep_d = !hold;
          rs_d = R_LEN;
        end
        R_LEN: begin
          if (rx_byte_q > `HPLF_MAX_LEN) begin
            rs_d = R_TYPE;
            drop_d = 1'b1;
          end else begin
            rlen_d = rx_byte_q[4:0];
            rcrc_d = crc_next(rcrc_q, rx_byte_q);
            ridx_d = '0;
            rs_d = (rx_byte_q == 8'h00) ? R_CRCL : R_DATA;
          end
        end
        R_DATA: begin
          buf_we = rkeep_q;
          buf_wa = ridx_q;
          buf_wd = rx_byte_q;
          rcrc_d = crc_next(rcrc_q, rx_byte_q);
          ridx_d = ridx_q + 1'b1;
          if (ridx_q == rlen_q - 1'b1) begin
            rs_d = R_CRCL;
          end
        end
        R_CRCL: begin
          rcvl_d = rx_byte_q;
          rs_d = R_CRCH;
        end
        R_CRCH: begin
          rs_d = R_TYPE;
          if ({rx_byte_q, rcvl_q} == ~rcrc_q) begin
            good = rkeep_q;
            drop_d = !rkeep_q;
          end else begin
            drop_d = 1'b1;
          end
        end
      endcase
    end else if (hold && i_ans_wr) begin
      buf_we = (i_cmd_idx < 5'(`HPLF_MAX_LEN));
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rs_q <= R_TYPE;
      rtype_q <= '0;
      rcvl_q <= '0;
      rlen_q <= '0;
      ridx_q <= '0;
      rcrc_q <= `HPLF_CRC_INIT;
      rkeep_q <= 1'b0;
      o_drop <= 1'b0;
    end else begin
      rs_q <= rs_d;
      rtype_q <= rtype_d;
      rcvl_q <= rcvl_d;
      rlen_q <= rlen_d;
      ridx_q <= ridx_d;
      rcrc_q <= rcrc_d;
      rkeep_q <= rkeep_d;
      o_drop <= drop_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (buf_we) begin
      buf_q[buf_wa] <= buf_wd;
    end
    o_cmd_byte <= (i_cmd_idx < 5'(`HPLF_MAX_LEN)) ? buf_q[i_cmd_idx] : 8'h00;
  end

  // Answer logic: one reply per accepted packet, forced to an error if the user is late.
  logic pend_q, pend_d, rep_q, rep_d, cmdv_d, tx_take;
  logic [7:0] rep_type_q, rep_type_d;
  logic [4:0] rep_len_q, rep_len_d;
  logic [23:0] wd_q, wd_d;
  hplf_pkg::hplf_cmd_t cmd_d;

  always_comb begin
    pend_d = pend_q;
    rep_d = rep_q && !tx_take;
    rep_type_d = rep_type_q;
    rep_len_d = rep_len_q;
    wd_d = wd_q;
    cmdv_d = 1'b0;
    cmd_d = o_cmd;
    if (good) begin
      rep_len_d = '0;
      if (rtype_q[7:6] != hplf_pkg::HPLF_CLS_CMD) begin
        rep_d = 1'b1;
        rep_type_d = {hplf_pkg::HPLF_CLS_ERR, rtype_q[5:0]};
      end else if (rtype_q[5:0] == `HPLF_ECHO_CODE) begin
        rep_d = 1'b1;
        rep_type_d = {hplf_pkg::HPLF_CLS_RSP, rtype_q[5:0]};
        rep_len_d = rlen_q;
      end else begin
        pend_d = 1'b1;
        wd_d = '0;
        cmdv_d = 1'b1;
        cmd_d = '{code: rtype_q[5:0], len: rlen_q};
      end
    end else if (pend_q) begin
      wd_d = wd_q + 1'b1;
      if (i_ans_valid) begin
        pend_d = 1'b0;
        rep_d = 1'b1;
        rep_type_d = {i_ans.err ? hplf_pkg::HPLF_CLS_ERR : hplf_pkg::HPLF_CLS_RSP, o_cmd.code};
        rep_len_d = (i_ans.len > 5'(`HPLF_MAX_LEN)) ? 5'(`HPLF_MAX_LEN) : i_ans.len;
      end else if (wd_q == 24'(P_ANS_LIMIT_CYC - 1)) begin
        pend_d = 1'b0;
        rep_d = 1'b1;
        rep_type_d = {hplf_pkg::HPLF_CLS_ERR, o_cmd.code};
        rep_len_d = '0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pend_q <= 1'b0;
      rep_q <= 1'b0;
      rep_type_q <= '0;
      rep_len_q <= '0;
      wd_q <= '0;
      o_cmd_valid <= 1'b0;
      o_cmd <= '0;
    end else begin
      pend_q <= pend_d;
      rep_q <= rep_d;
      rep_type_q <= rep_type_d;
      rep_len_q <= rep_len_d;
      wd_q <= wd_d;
      o_cmd_valid <= cmdv_d;
      o_cmd <= cmd_d;
    end
  end

  // Packet sender. Back-pressure from the FIFO simply stalls it.
  hplf_tx_st_t ts_q, ts_d;
  logic [7:0] t_type_q, t_type_d, t_byte;
  logic [4:0] t_len_q, t_len_d, t_idx_q, t_idx_d;
  logic [15:0] t_crc_q, t_crc_d;
  logic [31:0] t_rdat_q, t_rdat_d;
  logic t_rep_q, t_rep_d, t_push, f_ready, rpt_tk_d;

  assign tx_take = (ts_q == T_IDLE) && rep_q;
  assign hold = pend_q || rep_q || ((ts_q != T_IDLE) && t_rep_q);

  always_comb begin
    ts_d = ts_q;
    t_type_d = t_type_q;
    t_len_d = t_len_q;
    t_idx_d = t_idx_q;
    t_crc_d = t_crc_q;
    t_rdat_d = t_rdat_q;
    t_rep_d = t_rep_q;
    rpt_tk_d = 1'b0;
    t_push = 1'b0;
    t_byte = 8'h00;
    unique case (ts_q)
      T_IDLE: begin
        if (rep_q) begin
          ts_d = T_TYPE;
          t_type_d = rep_type_q;
          t_len_d = rep_len_q;
          t_rep_d = 1'b1;
        end else if (i_rpt_valid) begin
          ts_d = T_TYPE;
          t_type_d = {hplf_pkg::HPLF_CLS_RPT, i_rpt.code};
          t_len_d = (i_rpt.len > `HPLF_RPT_MAX_LEN) ? 5'(`HPLF_RPT_MAX_LEN) : 5'(i_rpt.len);
          t_rdat_d = i_rpt.data;
          t_rep_d = 1'b0;
          rpt_tk_d = 1'b1;
        end
        t_crc_d = `HPLF_CRC_INIT;
        t_idx_d = '0;
      end
      T_TYPE: begin
        t_byte = t_type_q;
        t_push = 1'b1;
      end
      T_LEN: begin
        t_byte = {3'h0, t_len_q};
        t_push = 1'b1;
      end
      T_DATA: begin
        t_byte = t_rep_q ? buf_q[t_idx_q] : t_rdat_q[7:0];
        t_push = 1'b1;
      end
      T_CRCL: begin
        t_byte = ~t_crc_q[7:0];
        t_push = 1'b1;
      end
      T_CRCH: begin
        t_byte = ~t_crc_q[15:8];
        t_push = 1'b1;
      end
    endcase
    if (t_push && f_ready) begin
      if (ts_q != T_CRCL && ts_q != T_CRCH) begin
        t_crc_d = crc_next(t_crc_q, t_byte);
      end
      unique case (ts_q)
        T_TYPE: ts_d = T_LEN;
        T_LEN: ts_d = (t_len_q == '0) ? T_CRCL : T_DATA;
        T_DATA: begin
          t_idx_d = t_idx_q + 1'b1;
          t_rdat_d = {8'h00, t_rdat_q[31:8]};
          ts_d = (t_idx_q == t_len_q - 1'b1) ? T_CRCL : T_DATA;
        end
        T_CRCL: ts_d = T_CRCH;
        default: ts_d = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ts_q <= T_IDLE;
      t_type_q <= '0;
      t_len_q <= '0;
      t_idx_q <= '0;
      t_crc_q <= `HPLF_CRC_INIT;
      t_rdat_q <= '0;
      t_rep_q <= 1'b0;
      o_rpt_taken <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      ts_q <= ts_d;
      t_type_q <= t_type_d;
      t_len_q <= t_len_d;
      t_idx_q <= t_idx_d;
      t_crc_q <= t_crc_d;
      t_rdat_q <= t_rdat_d;
      t_rep_q <= t_rep_d;
      o_rpt_taken <= rpt_tk_d;
      o_busy <= pend_d || rep_d;
    end
  end

  // Serial transmitter draining the FIFO; no flow-control input exists.
  logic f_valid, ut_act_q, ut_act_d, f_pop;
  logic [7:0] f_data;
  logic [15:0] ut_div_q, ut_div_d;
  logic [3:0] ut_bit_q, ut_bit_d;
  logic [9:0] ut_sh_q, ut_sh_d;

  hplf_fifo #(.WIDTH(8), .DEPTH(P_FIFO_DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(t_push),
    .i_in_data(t_byte),
    .o_in_ready(f_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_pop)
  );

  assign f_pop = !ut_act_q;

  always_comb begin
    ut_act_d = ut_act_q;
    ut_div_d = ut_div_q;
    ut_bit_d = ut_bit_q;
    ut_sh_d = ut_sh_q;
    if (!ut_act_q) begin
      if (f_valid) begin
        ut_act_d = 1'b1;
        ut_sh_d = {1'b1, f_data, 1'b0};
        ut_div_d = 16'(P_BAUD_DIV - 1);
        ut_bit_d = '0;
      end
    end else if (ut_div_q != '0) begin
      ut_div_d = ut_div_q - 1'b1;
    end else begin
      ut_div_d = 16'(P_BAUD_DIV - 1);
      ut_sh_d = {1'b1, ut_sh_q[9:1]};
      ut_bit_d = ut_bit_q + 1'b1;
      ut_act_d = (ut_bit_q != 4'h9);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ut_act_q <= 1'b0;
      ut_div_q <= '0;
      ut_bit_q <= '0;
      ut_sh_q <= 10'h3FF;
      o_txd <= 1'b1;
    end else begin
      ut_act_q <= ut_act_d;
      ut_div_q <= ut_div_d;
      ut_bit_q <= ut_bit_d;
      ut_sh_q <= ut_sh_d;
      o_txd <= ut_act_d ? ut_sh_d[0] : 1'b1;
    end
  end
endmodule // hplf_framer

/* File: tb/hplf_framer_properties.sv */
// Concurrent checks on the packet framer, watching only its top-level ports.
// Assumes one clock and a synchronous active-high reset; attached by the bind below.
module hplf_framer_properties #(
  parameter int P_ANS_LIMIT_CYC = 2000,
  parameter int P_BAUD_DIV = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic o_txd,
  input wire logic o_cmd_valid,
  input wire hplf_pkg::hplf_cmd_t o_cmd,
  input wire logic i_rpt_valid,
  input wire logic o_rpt_taken,
  input wire logic o_drop,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] low_q;
  logic [31:0] low_d;
  logic [31:0] busy_q;
  logic [31:0] busy_d;

  // Low runs on the line must be whole bit times; the busy run bounds the answer time.
  always_comb begin
    low_d = o_txd ? 32'h0000_0000 : low_q + 32'h0000_0001;
    busy_d = o_busy ? busy_q + 32'h0000_0001 : 32'h0000_0000;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      low_q <= 32'h0000_0000;
      busy_q <= 32'h0000_0000;
    end else begin
      low_q <= low_d;
      busy_q <= busy_d;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence s_release;
    $fell(i_reset);
  endsequence

  sequence s_take;
    $past(i_rpt_valid) ##1 !o_rpt_taken;
  endsequence

  reset_idle_a: assert property (s_release |-> o_txd && !o_busy && !o_cmd_valid)
    else $error("outputs not idle after reset");
  cmd_pulse_a: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command strobe longer than one cycle");
  cmd_busy_a: assert property (o_cmd_valid |-> o_busy)
    else $error("command offered while not busy");
  cmd_fields_a: assert property (o_cmd_valid |-> o_cmd.code != 6'h00 && o_cmd.len <= 5'h16)
    else $error("command code or length out of range");
  rpt_take_a: assert property (o_rpt_taken |-> s_take)
    else $error("report taken without a request");
  drop_pulse_a: assert property (o_drop |-> !o_cmd_valid ##1 !o_drop)
    else $error("drop strobe malformed");
  bit_width_a: assert property ($rose(o_txd) |-> low_q != 0 && low_q % P_BAUD_DIV == 0)
    else $error("line low run is not whole bit times");
  ans_limit_a: assert property (busy_q <= P_ANS_LIMIT_CYC + 400 * P_BAUD_DIV)
    else $error("pending command not answered in time");
endmodule // hplf_framer_properties

bind hplf_framer hplf_framer_properties #(
  .P_ANS_LIMIT_CYC(P_ANS_LIMIT_CYC),
  .P_BAUD_DIV(P_BAUD_DIV)
) i_hplf_framer_properties (
  .i_clk_sys, .i_reset, .o_txd, .o_cmd_valid, .o_cmd, .i_rpt_valid, .o_rpt_taken, .o_drop,
  .o_busy
);

/* File: tb/hplf_host_model.sv */
// Host side of the serial link: sends checksummed packets and decodes every returned byte.
// Assumes the line idles high and the bench calls send_pkt one packet at a time.
module hplf_host_model #(
  parameter int P_BAUD_DIV = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_txd_dev,
  output logic o_rxd_dev,
  output logic o_byte_stb,
  output logic [7:0] o_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk_sys);
      o_rxd_dev = f[i];
      repeat (P_BAUD_DIV - 1) @(negedge i_clk_sys);
    end
  endtask

  // A set flip bit corrupts the checksum on purpose.
  task automatic send_pkt(input logic [7:0] q[$], input logic flip);
    logic [15:0] c;
    c = crc16(q);
    c[0] = c[0] ^ flip;
    foreach (q[i]) send_byte(q[i]);
    send_byte(c[7:0]);
    send_byte(c[15:8]);
  endtask

  // Bytes are handed on at once, so the host never falls behind the link.
  initial begin
    o_rxd_dev = 1'b1;
    o_byte_stb = 1'b0;
    o_byte = 8'h00;
    forever begin
      @(negedge i_clk_sys);
      o_byte_stb = 1'b0;
      // Every byte is framed afresh from its own start bit, so a lost byte costs one byte only.
      if (i_txd_dev === 1'b0) begin
        repeat (P_BAUD_DIV / 2) @(negedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
          repeat (P_BAUD_DIV) @(negedge i_clk_sys);
          o_byte[i] = i_txd_dev;
        end
        repeat (P_BAUD_DIV) @(negedge i_clk_sys);
        o_byte_stb = (i_txd_dev === 1'b1);
      end
    end
  end
endmodule // hplf_host_model

/* File: tb/hplf_framer_tb.sv */
// Self-checking bench: the host model works the line, the user side is driven here.
// Assumes the framer, its FIFO, the host model and the property checker are compiled.
module hplf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P_BAUD_DIV = 8;
  localparam int P_ANS_LIMIT_CYC = 2000;
  localparam int P_MAX_CYC = 60000;
  logic i_clk_sys, i_reset, i_rxd, o_txd, o_cmd_valid, i_ans_wr, i_ans_valid;
  logic i_rpt_valid, o_rpt_taken, o_drop, o_busy, rx_stb;
  logic [4:0] i_cmd_idx;
  logic [7:0] o_cmd_byte, i_ans_byte, rx_byte;
  hplf_pkg::hplf_cmd_t o_cmd;
  hplf_pkg::hplf_ans_t i_ans;
  hplf_pkg::hplf_rpt_t i_rpt;
  logic [7:0] exp_q[$];
  logic [7:0] pkt[$];
  logic [31:0] seed = 32'h0706_c7a6;
  int n_fail, check_count, n_cmd, n_drop, cyc, c0;
  int lens[3] = '{0, 22, 7};

  hplf_framer #(.P_ANS_LIMIT_CYC(P_ANS_LIMIT_CYC), .P_BAUD_DIV(P_BAUD_DIV)) i_hplf_framer (
    .i_clk_sys, .i_reset, .i_rxd, .o_txd, .o_cmd_valid, .o_cmd, .i_cmd_idx, .o_cmd_byte,
    .i_ans_wr, .i_ans_byte, .i_ans_valid, .i_ans, .i_rpt_valid, .i_rpt, .o_rpt_taken,
    .o_drop, .o_busy);
  hplf_host_model #(.P_BAUD_DIV(P_BAUD_DIV)) i_hplf_host_model (
    .i_clk_sys, .i_txd_dev(o_txd), .o_rxd_dev(i_rxd), .o_byte_stb(rx_stb), .o_byte(rx_byte));

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic check_flag(input string what, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask

  task automatic mk(input logic [7:0] t, input int n);
    pkt = {t, 8'(n)};
    for (int i = 0; i < n; i++) pkt.push_back(8'(rnd()));
  endtask

  task automatic expect_pkt(input logic [7:0] t, input int n);
    logic [7:0] q[$];
    logic [15:0] c;
    q = {t, 8'(n)};
    for (int i = 0; i < n; i++) q.push_back(pkt[i + 2]);
    c = i_hplf_host_model.crc16(q);
    exp_q = {exp_q, q, c[7:0], c[15:8]};
  endtask

  task automatic wait_pulse(ref int cnt, input int old);
    for (int i = 0; i < 4000 && cnt == old; i++) @(negedge i_clk_sys);
  endtask

  // The next test waits here until the expected answer is complete.
  task automatic settle(input string name);
    for (int i = 0; i < 20000 && exp_q.size() != 0; i++) @(negedge i_clk_sys);
    repeat (40 * P_BAUD_DIV) @(negedge i_clk_sys);
    check_flag("reply complete", 1'b1, exp_q.size() == 0);
    check_flag("busy after reply", 1'b0, o_busy);
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    if (o_cmd_valid === 1'b1) n_cmd++;
    if (o_drop === 1'b1) n_drop++;
    if (rx_stb === 1'b1) begin
      if (exp_q.size() == 0) check_flag("reply byte wanted", 1'b0, 1'b1);
      else check_byte("reply byte", exp_q.pop_front(), rx_byte);
    end
    cyc++;
    if (cyc == P_MAX_CYC) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    i_reset = 1'b1;
    {i_ans_wr, i_ans_valid, i_rpt_valid, i_cmd_idx, i_ans_byte} = '0;
    i_ans = '0;
    i_rpt = '0;
    repeat (6) @(negedge i_clk_sys);
    i_reset = 1'b0;
    foreach (lens[k]) begin
      mk(8'h00, lens[k]);
      expect_pkt(8'h40, lens[k]);
      i_hplf_host_model.send_pkt(pkt, 1'b0);
      settle("echo");
    end
    for (int k = 1; k < 4; k++) begin
      mk({2'(k), 6'(rnd())}, 2);
      expect_pkt({2'b11, pkt[0][5:0]}, 0);
      i_hplf_host_model.send_pkt(pkt, 1'b0);
      settle("class");
    end
    mk(8'h05, 2);
    c0 = n_cmd;
    i_hplf_host_model.send_pkt(pkt, 1'b0);
    wait_pulse(n_cmd, c0);
    check_byte("command code", 8'h05, {2'b00, o_cmd.code});
    check_flag("busy while pending", 1'b1, o_busy);
    check_byte("command length", 8'h02, {3'b000, o_cmd.len});
    for (int i = 0; i < 2; i++) begin
      i_cmd_idx = 5'(i);
      @(negedge i_clk_sys);
      check_byte("command payload", pkt[i + 2], o_cmd_byte);
    end
    for (int i = 0; i < 2; i++) begin
      i_ans_wr = 1'b1;
      i_cmd_idx = 5'(i);
      i_ans_byte = ~pkt[i + 2];
      pkt[i + 2] = ~pkt[i + 2];
      @(negedge i_clk_sys);
    end
    i_ans_wr = 1'b0;
    expect_pkt(8'h45, 2);
    // A packet arriving while a command is pending must vanish without a reply.
    mk(8'h00, 1);
    c0 = n_drop;
    i_hplf_host_model.send_pkt(pkt, 1'b0);
    wait_pulse(n_drop, c0);
    check_flag("busy drop", 1'b1, n_drop == c0 + 1);
    i_ans = '{err: 1'b0, len: 5'd2};
    i_ans_valid = 1'b1;
    @(negedge i_clk_sys);
    i_ans_valid = 1'b0;
    settle("answer");
    mk(8'h3f, 0);
    c0 = n_cmd;
    expect_pkt(8'hff, 0);
    i_hplf_host_model.send_pkt(pkt, 1'b0);
    wait_pulse(n_cmd, c0);
    i_ans = '{err: 1'b1, len: 5'd0};
    i_ans_valid = 1'b1;
    @(negedge i_clk_sys);
    i_ans_valid = 1'b0;
    settle("error answer");
    mk(8'h21, 0);
    expect_pkt(8'he1, 0);
    i_hplf_host_model.send_pkt(pkt, 1'b0);
    settle("no answer");
    // A report asking for more than four bytes is cut to four.
    i_rpt = '{code: 6'h12, len: 3'd7, data: rnd()};
    pkt = {8'h92, 8'h04};
    for (int i = 0; i < 4; i++) pkt.push_back(i_rpt.data[8 * i +: 8]);
    expect_pkt(8'h92, 4);
    i_rpt_valid = 1'b1;
    for (int i = 0; i < 2000 && o_rpt_taken !== 1'b1; i++) @(negedge i_clk_sys);
    check_flag("report taken", 1'b1, o_rpt_taken);
    i_rpt_valid = 1'b0;
    settle("report");
    mk(8'h00, 4);
    c0 = n_drop;
    i_hplf_host_model.send_pkt(pkt, 1'b1);
    wait_pulse(n_drop, c0);
    check_flag("checksum drop", 1'b1, n_drop == c0 + 1);
    settle("bad checksum");
    pkt = {8'h00, 8'h17};
    for (int i = 0; i < 23; i++) pkt.push_back(8'h00);
    c0 = n_drop;
    i_hplf_host_model.send_pkt(pkt, 1'b0);
    wait_pulse(n_drop, c0);
    check_flag("length drop", 1'b1, n_drop > c0);
    settle("bad length");
    summarize();
  end
endmodule // hplf_framer_tb
